// *** rtl/ahh_host.sv ***
// Host controller that runs conversions on the half-flash converter
`timescale 1ns/1ps
`default_nettype none
`include "ahh_defs.svh"

// Flow of one conversion, per request kind:
//   single-access: select and read fall together; the converter holds
//   wait low while it works, then drops done; read stays low three more
//   cycles so the result byte has crossed the synchroniser
//   polled fetch: select and start fall together; start rises after
//   the upper-nibble time; done is awaited, then read fetches the byte
//   fast fetch: as polled, but read falls a fixed time after start
//   rises and done is ignored; the early read forces the latch
// Every conversion ends with select and read rising together, which
// clears done in all modes; then the tracking gap runs before the next
// request is taken.
// Shared pin: its enable falls with each fetch request and stays low until a single-access request is taken;
// in single-access it stays high so the wait output of the converter
// owns the line.
// Spans count whole cycles rounded up, the poll timeout one more, so each
// least time is met with up to one cycle to spare (two for the poll timeout), at the cost of a little throughput.
// Limitation: single-access has no bound of its own; a converter that
// never answers holds the sequencer in the read state until reset.
// Data, valid and pins come straight from flops; only the ready
module ahh_host
    import ahh_pkg::*;
(
    input  wire logic                   clk_in,
    input  wire logic                   sys_rst_in,
    input  wire logic                   req_valid_in,
    input  wire ahh_op_t                req_op_in,
    output logic                        req_ready_out,
    output logic                        res_valid_out,
    output logic [`AHH_DATA_W-1:0]      res_data_out,
    input  wire logic                   res_ready_in,
    output ahh_pins_out_t               pins_out,
    input  wire ahh_pins_in_t           pins_in
);
    typedef enum logic [2:0] {
        // Waiting spans
        S_GAP,
        S_IDLE,
        // Start pulse of the fetch modes
        S_START_LOW,
        S_START_HIGH,
        // Read strobe low, then result handed over
        S_READ,
        S_SETTLE,
        S_RESULT
    } ahh_state_t;

    typedef struct packed {
        // Sequencer position and the kind of the running request
        ahh_state_t               fsm;
        ahh_op_t                  op;
        // One counter serves every timed span, cleared as each span starts
        logic [`AHH_CNT_W-1:0]    cnt;
        // Registered drive of the converter pins, so no glitch reaches them
        ahh_pins_out_t            pins;
        // Result held for the consumer
        logic                     valid;
        logic [`AHH_DATA_W-1:0]   data;
    } ahh_host_state_t;

    ahh_host_state_t st;
    ahh_host_state_t next_st;
    ahh_pins_in_t    pin_s;

    // Span ends and converter status, decoded once per cycle
    logic            gap_done;
    logic            start_low_done;
    logic            fast_read_due;
    logic            poll_timeout;
    logic            done_seen;
    logic            wait_released;
    logic            sync_flushed;
    logic            settle_done;
    logic            op_single;

    // Every converter input passes two flops before use
    ahh_sync #(.W($bits(ahh_pins_in_t))) u_sync (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .async_in   (pins_in),
        .sync_out   (pin_s)
    );

    // Span ends, each a count of whole cycles rounded up from the least time; the poll timeout runs one cycle more
    assign gap_done       = (st.cnt >= `AHH_CNT_W'(`AHH_GAP_CYC - 1));
    assign start_low_done = (st.cnt >= `AHH_CNT_W'(`AHH_START_LOW_CYC - 1));
    assign fast_read_due  = (st.cnt >= `AHH_CNT_W'(`AHH_FAST_RD_CYC - 1));
    assign poll_timeout   = (st.cnt >= `AHH_CNT_W'(`AHH_DONE_WAIT_CYC));

    // Converter status as seen after the synchroniser
    assign done_seen      = !pin_s.done_n;
    assign wait_released  = pin_s.wait_n;

    // Synchroniser still shows pre-strobe values for its two stages
    assign sync_flushed   = (st.cnt > `AHH_CNT_W'(2));
    // Data must stand three cycles on the bus before it is taken
    assign settle_done    = (st.cnt >= `AHH_CNT_W'(2));

    // Request kind decoded once for the idle branch
    assign op_single      = (req_op_in == AHH_OP_SINGLE);

    // Conversion sequencer
    always_comb begin
        next_st = st;
        // Counter runs by default; idle and result hold it at zero, and each move into a timed span clears it
        next_st.cnt = st.cnt + `AHH_CNT_W'(1);
        unique case (st.fsm)
            // Tracking time before any new start edge
            S_GAP: begin
                if (gap_done) begin
                    next_st.fsm = S_IDLE;
                end
            end

            // Start on user request; a precise timer may drive it
            S_IDLE: begin
                next_st.cnt = '0;
                if (req_valid_in) begin
                    next_st.op        = req_op_in;
                    next_st.pins.mode = !op_single;
                    next_st.pins.cs_n = 1'b0;
                    if (op_single) begin
                        // Read fall samples and starts
                        next_st.pins.rd_n       = 1'b0;
                        next_st.pins.start_oe_n = 1'b1;
                        next_st.fsm             = S_READ;
                    end else begin
                        // Start fall samples the input
                        next_st.pins.start_oe_n = 1'b0;
                        next_st.pins.start_n    = 1'b0;
                        next_st.fsm             = S_START_LOW;
                    end
                end
            end

            // Hold start low for the upper-nibble compare
            S_START_LOW: begin
                if (start_low_done) begin
                    next_st.pins.start_n = 1'b1;
                    next_st.cnt          = '0;
                    next_st.fsm          = S_START_HIGH;
                end
            end

            // Polled waits for done fast read waits 250 ns
            S_START_HIGH: begin
                if (st.op == AHH_OP_FAST) begin
                    if (fast_read_due) begin
                        next_st.pins.rd_n = 1'b0;
                        next_st.cnt       = '0;
                        next_st.fsm       = S_SETTLE;
                    end
                end else if (done_seen || poll_timeout) begin
                    // Timeout bounds a lost flag
                    next_st.pins.rd_n = 1'b0;
                    next_st.cnt       = '0;
                    next_st.fsm       = S_SETTLE;
                end
            end

            // Single-access: wait released, done low
            S_READ: begin
                if (wait_released && done_seen && sync_flushed) begin
                    next_st.cnt = '0;
                    next_st.fsm = S_SETTLE;
                end
            end

            // Bus driven only with select and read low
            S_SETTLE: begin
                if (settle_done) begin
                    next_st.data      = pin_s.data;
                    next_st.valid     = 1'b1;
                    // Releasing both clears the done flag
                    next_st.pins.rd_n = 1'b1;
                    next_st.pins.cs_n = 1'b1;
                    next_st.fsm       = S_RESULT;
                end
            end

            // Result stands until the consumer takes it
            S_RESULT: begin
                next_st.cnt = '0;
                if (res_ready_in) begin
                    next_st.valid = 1'b0;
                    next_st.fsm   = S_GAP;
                end
            end

            // Unused code falls back to the safe gap
            default: begin
                next_st.fsm = S_GAP;
            end
        endcase
    end

    // Single register of all state
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            // Pins idle high, shared pin released, single mode
            st                 <= '0;
            st.fsm             <= S_GAP;
            st.pins.cs_n       <= 1'b1;
            st.pins.rd_n       <= 1'b1;
            st.pins.start_n    <= 1'b1;
            st.pins.start_oe_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Ready decoded from state; valid, data and pins straight from flops
    assign req_ready_out = (st.fsm == S_IDLE);
    assign res_valid_out = st.valid;
    assign res_data_out  = st.data;
    assign pins_out      = st.pins;
endmodule : ahh_host
`default_nettype wire

// *** rtl/ahh_defs.svh ***
// Constants of the converter host handshake controller
`ifndef AHH_DEFS_SVH
`define AHH_DEFS_SVH
`define AHH_CLK_PERIOD_PS   25000
`define AHH_T_GAP_NS        350
`define AHH_T_START_LOW_NS  250
`define AHH_T_FAST_RD_NS    250
`define AHH_T_DONE_NS       380
`define AHH_T_STANDALONE_NS 530
// Least times round up, in cycles
`define AHH_CYC_UP(ns) \
    (((ns) * 1000 + `AHH_CLK_PERIOD_PS - 1) / `AHH_CLK_PERIOD_PS)
`define AHH_GAP_CYC        `AHH_CYC_UP(`AHH_T_GAP_NS)
`define AHH_START_LOW_CYC  `AHH_CYC_UP(`AHH_T_START_LOW_NS)
`define AHH_FAST_RD_CYC    `AHH_CYC_UP(`AHH_T_FAST_RD_NS)
`define AHH_DONE_WAIT_CYC  `AHH_CYC_UP(`AHH_T_STANDALONE_NS)
`define AHH_CNT_W          6
`define AHH_DATA_W         8
`endif

// *** rtl/ahh_pkg.sv ***
// Types of the converter host handshake controller
`include "ahh_defs.svh"
package ahh_pkg;
    typedef enum logic [1:0] {
        AHH_OP_SINGLE = 2'h0,
        AHH_OP_POLLED = 2'h1,
        AHH_OP_FAST   = 2'h2
    } ahh_op_t;

    // Pins driven toward the converter
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic start_n;
        logic start_oe_n;
        logic mode;
    } ahh_pins_out_t;

    // Pins sampled from the converter
    typedef struct packed {
        logic                    done_n;
        logic                    wait_n;
        logic [`AHH_DATA_W-1:0]  data;
    } ahh_pins_in_t;
endpackage : ahh_pkg

// *** rtl/ahh_sync.sv ***
// Two-flop synchroniser for converter pins
`timescale 1ns/1ps
`default_nettype none
module ahh_sync
    import ahh_pkg::*;
#(
    parameter int W = 10
) (
    input  wire logic         clk_in,
    input  wire logic         sys_rst_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] first;
        logic [W-1:0] second;
    } ahh_sync_state_t;
    ahh_sync_state_t st;
    ahh_sync_state_t next_st;

    // First stage feeds only the second; idle pins read high after reset
    always_comb begin
        next_st.first  = async_in;
        next_st.second = st.first;
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st <= '1;
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.second;
endmodule : ahh_sync
`default_nettype wire

// *** test/ahh_chk_assertions.sv ***
// Assertions on the converter host controller ports
`timescale 1ns/1ps
`default_nettype none
module ahh_chk
    import ahh_pkg::*;
(
    input wire logic          clk_in,
    input wire logic          sys_rst_in,
    input wire logic          req_valid_in,
    input wire ahh_op_t       req_op_in,
    input wire logic          req_ready_out,
    input wire logic          res_valid_out,
    input wire logic [7:0]    res_data_out,
    input wire logic          res_ready_in,
    input wire ahh_pins_out_t pins_out,
    input wire ahh_pins_in_t  pins_in
);
    wire        cs_n = pins_out.cs_n;
    wire        rd_n = pins_out.rd_n;
    wire        st_n = pins_out.start_n;
    wire        md   = pins_out.mode;
    logic [4:0] gap;
    // Idle span of select; saturates so a long idle never wraps
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || !cs_n) begin
            gap <= 5'h00;
        end else if (gap != 5'h1f) begin
            gap <= gap + 5'h01;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    property p_gap; $fell(cs_n) |-> gap >= 5'h0e; endproperty
    a_gap: assert property (p_gap) else $error("idle");
    property p_wlow; $rose(st_n) |-> !$past(st_n, 10); endproperty
    a_wlow: assert property (p_wlow) else $error("start");
    property p_fast; $fell(rd_n) && md |-> $past(st_n, 10); endproperty
    a_fast: assert property (p_fast) else $error("early");
    property p_hold; !md && !cs_n && !rd_n && pins_in.done_n
        |=> !cs_n && !rd_n; endproperty
    a_hold: assert property (p_hold) else $error("drop");
    property p_ack; $rose(rd_n) && !md |-> !$past(pins_in.done_n, 2)
        && $past(pins_in.wait_n, 2); endproperty
    a_ack: assert property (p_ack) else $error("ack");
    property p_strt; $fell(st_n) |-> !cs_n && md && !pins_out.start_oe_n;
    endproperty
    a_strt: assert property (p_strt) else $error("strobe");
    property p_mode; !md |-> pins_out.start_oe_n; endproperty
    a_mode: assert property (p_mode) else $error("mode");
    property p_cap; $rose(res_valid_out) |-> !$past(rd_n) && !$past(cs_n);
    endproperty
    a_cap: assert property (p_cap) else $error("capture");
    c_single: cover property ($rose(res_valid_out) && !md);
    c_fast: cover property ($fell(rd_n) && md && $past(pins_in.done_n));
    c_poll: cover property ($fell(rd_n) && md && !$past(pins_in.done_n));
endmodule : ahh_chk
bind ahh_host ahh_chk u_chk (.clk_in, .sys_rst_in, .req_valid_in,
    .req_op_in, .req_ready_out, .res_valid_out, .res_data_out,
    .res_ready_in, .pins_out, .pins_in);
`default_nettype wire

// *** test/ahh_adc_model.sv ***
// Behavioural converter seen from its host pins
`timescale 1ns/1ps
`default_nettype none
module ahh_adc_model
    import ahh_pkg::*;
#(
    parameter int CONV_NS = 610,
    parameter int DONE_NS = 380
) (
    input  wire ahh_pins_out_t host_in,
    input  wire logic [7:0]    ain_in,
    output var logic           done_n_out,
    output var logic           wait_oe_n_out,
    output logic [7:0]         db_out
);
    logic [7:0] smp  = 8'h00;
    logic [7:0] res  = 8'h00;
    logic       pend = 1'b0;
    initial {done_n_out, wait_oe_n_out} = 2'b11;
    // Read fall: single-access start, or early fetch after a start
    always @(negedge host_in.rd_n) if (!host_in.cs_n) begin
        if (!host_in.mode) begin
            {smp, wait_oe_n_out} = {ain_in, 1'b0};
            #(CONV_NS);
            {res, done_n_out, wait_oe_n_out} = {smp, 2'b01};
        end else if (pend) begin
            {res, done_n_out, pend} = {smp, 2'b00};
        end
    end
    // Start fall samples; its rise keeps the top nibble
    always @(negedge host_in.start_n) if (host_in.mode && !host_in.cs_n)
        {smp, pend} = {ain_in, 1'b1};
    always @(posedge host_in.start_n) if (pend) begin
        res[7:4] = smp[7:4];
        #(DONE_NS);
        if (pend) {res, done_n_out, pend} = {smp, 2'b00};
    end
    // Either strobe rising clears the flag
    always @(posedge host_in.cs_n or posedge host_in.rd_n)
        done_n_out = 1'b1;
    // Released bus shows the inverse, never a stale copy
    assign db_out = (!host_in.cs_n && !host_in.rd_n) ? res : ~res;
endmodule : ahh_adc_model
`default_nettype wire

// *** test/testbench.sv ***
// Bench: host controller driving a converter model
`timescale 1ns/1ps
`default_nettype none
module testbench
    import ahh_pkg::*;
;
    logic          clk_in = 1'b0, sys_rst_in = 1'b1, req_valid_in = 1'b0;
    logic          res_ready_in = 1'b0, req_ready_out, res_valid_out;
    logic          done_n, wt_n;
    logic [7:0]    res_data_out, db, ain = 8'h00;
    ahh_op_t       req_op_in = AHH_OP_SINGLE;
    ahh_pins_out_t pins_out;
    ahh_pins_in_t  pins_in;
    int            n_fail = 0, n_compared = 0;
    // Wait line taken straight from the model, which drives it both low and high
    assign pins_in = {done_n, wt_n, db};
    initial forever #12.5 clk_in = ~clk_in;
    ahh_host dut (.clk_in, .sys_rst_in, .req_valid_in, .req_op_in,
        .req_ready_out, .res_valid_out, .res_data_out, .res_ready_in,
        .pins_out, .pins_in);
    ahh_adc_model adc (.host_in(pins_out), .ain_in(ain),
        .done_n_out(done_n), .wait_oe_n_out(wt_n), .db_out(db));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        n_fail += int'(got !== exp);
        if (got !== exp) begin
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic final_report();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report
    // One conversion; the input moves just after the sampling edge
    task automatic conv(input ahh_op_t op, input logic [7:0] v);
        ain = v;
        repeat (40) if (req_ready_out !== 1'b1) @(negedge clk_in);
        {req_op_in, req_valid_in} = {op, 1'b1};
        @(negedge clk_in);
        req_valid_in = 1'b0;
        @(negedge clk_in);
        ain = ~v;
        chk(8'(pins_out.mode), 8'(op != AHH_OP_SINGLE));
        repeat (60) if (res_valid_out !== 1'b1) @(negedge clk_in);
        repeat (3) @(negedge clk_in);
        chk(res_data_out, v);
        res_ready_in = 1'b1;
        @(negedge clk_in);
        res_ready_in = 1'b0;
        chk(8'(res_valid_out), 8'h00);
    endtask : conv
    task automatic t_single();
        conv(AHH_OP_SINGLE, 8'hff);
        conv(AHH_OP_SINGLE, 8'h00);
    endtask : t_single
    task automatic t_start();
        conv(AHH_OP_POLLED, 8'h5a);
        conv(AHH_OP_FAST, 8'ha5);
        conv(AHH_OP_SINGLE, 8'h3c);
    endtask : t_start
    // Request held high: the next start must wait out the idle span
    task automatic t_gap();
        int n;
        {req_op_in, req_valid_in, res_ready_in} = {AHH_OP_FAST, 2'b11};
        repeat (40) if (pins_out.cs_n !== 1'b0) @(negedge clk_in);
        chk(8'(req_ready_out), 8'h00);
        repeat (60) if (pins_out.cs_n !== 1'b1) @(negedge clk_in);
        for (n = 0; n < 40 && pins_out.cs_n === 1'b1; n++) @(negedge clk_in);
        chk(8'(n >= 14), 8'h01);
        req_valid_in = 1'b0;
    endtask : t_gap
    initial begin
        repeat (8) @(negedge clk_in);
        sys_rst_in = 1'b0;
        t_single();
        t_start();
        t_gap();
        final_report();
    end
    // Cuts a hang short well past the expected run
    initial begin
        #40us;
        n_fail++;
        final_report();
    end
endmodule : testbench
`default_nettype wire
